// ===== common/pcache_pkg.sv
// Package for the pixel cache mode and maintenance block: register
// offsets, field positions, reset values and default operation lengths.
// Assumes a 32-bit register port addressed by byte offset.
package pcache_pkg;

	// Register byte offsets
	localparam logic [15:0] OTHER_MODE_OFS  = 16'h0180;
	localparam logic [15:0] ENGINE_MODE_OFS = 16'h1744;
	localparam logic [15:0] CTLSTAT_OFS     = 16'h1748;

	// Mode register layout, identical in both mode registers
	localparam int MODE_WIDTH         = 9;
	localparam logic [8:0] MODE_RESET = 9'h000;
	localparam int HOST_YIELD_BIT     = 0;
	localparam int FLUSH_RISE_EN_BIT  = 1;
	localparam int FLUSH_FALL_EN_BIT  = 2;
	localparam int BYPASS_BIT         = 3;
	localparam int HALF_CAP_BIT       = 4;
	localparam int IGNORE_MERGE_BIT   = 5;
	localparam int IGNORE_WR_LOCK_BIT = 6;
	localparam int IGNORE_RD_LOCK_BIT = 7;
	localparam int PURGE_RISE_EN_BIT  = 8;

	// Maintenance control/status layout
	localparam int ENG_FLUSH_LSB        = 0;
	localparam int ENG_RI_LSB           = 2;
	localparam int OTH_FLUSH_LSB        = 4;
	localparam int OTH_RI_LSB           = 6;
	localparam int PURGE_STATUS_BIT     = 25;
	localparam int EDGE_FLUSH_STAT_BIT  = 26;
	localparam int ENG_BUSY_STAT_BIT    = 29;
	localparam int OTH_BUSY_STAT_BIT    = 30;
	localparam logic [1:0] FIELD_RESET  = 2'h0;
	localparam logic [1:0] FIELD_ALL    = 2'h3;
	localparam logic [31:0] READ_ZERO   = 32'h0000_0000;

	// Default lengths of maintenance walks, in cache clocks
	localparam int DEF_FLUSH_CYCLES = 64;
	localparam int DEF_RI_CYCLES    = 32;

	// Sequencer states
	typedef enum logic {
		SEQ_IDLE,
		SEQ_RUN
	} seq_state_t;

endpackage

// ===== sim/pcache_client_model.sv
// Client-side model: engine clients, host port and drawing engine busy.
// Assumes the bench commands each level; outputs change on clk_in and clear at once when rst_b_in falls.
`timescale 1ns/1ps
`default_nettype none
module pcache_client_model (
	input  wire logic       clk_in,
	input  wire logic       rst_b_in,
	input  wire logic [4:0] cmd_in,
	output logic            eng_req_out,
	output logic            host_req_out,
	output logic            wr_hint_out,
	output logic            rd_hint_out,
	output logic            busy_out
);
	// Requests are held as levels until the bench withdraws them
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			eng_req_out  <= 1'b0;
			host_req_out <= 1'b0;
			wr_hint_out  <= 1'b0;
			rd_hint_out  <= 1'b0;
			busy_out     <= 1'b0;
		end else begin
			eng_req_out  <= cmd_in[0];
			host_req_out <= cmd_in[1];
			wr_hint_out  <= cmd_in[2];
			rd_hint_out  <= cmd_in[3];
			busy_out     <= cmd_in[4];
		end
	end
endmodule // pcache_client_model
`default_nettype wire

// ===== sim/pixel_cache_mode_and_maintenance_test.sv
// Self-checking bench for the pixel cache mode and maintenance control.
// Assumes short walk lengths (4 clocks) so each maintenance run is brief.
`timescale 1ns/1ps
`default_nettype none
module pixel_cache_mode_and_maintenance_test
	import pcache_pkg::*;
;
	logic        clk_in, rst_b_in, reg_wr, reg_rd, ext_flush, ext_purge;
	logic        alt_mode, merge_hint, eng_req, host_req, wr_hint, rd_hint;
	logic        eng_busy, eng_gnt, host_gnt, pass_thru, half_cap, four_way;
	logic        flush_act, inval_act, purge_busy, rise_busy, fall_busy;
	logic        engine_busy_out, other_busy_out;
	logic [1:0]  flush_chan;
	logic [4:0]  cmd;
	logic [15:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, m, v, rd;
	int          err_count, check_count, cyc, mode_m [2];
	logic [15:0] addr_tab [4] = '{OTHER_MODE_OFS, ENGINE_MODE_OFS,
		CTLSTAT_OFS, 16'h0200};
	logic [31:0] op_tab [9] = '{32'h01, 32'h02, 32'h03, 32'h10, 32'h20,
		32'h33, 32'h04, 32'h40, 32'hCC};
	logic [31:0] edge_mode [4] = '{32'h002, 32'h004, 32'h00A, 32'h100};
	logic [2:0]  edge_exp [4] = '{3'h4, 3'h2, 3'h0, 3'h1};

	pcache_client_model peer_u (.clk_in(clk_in), .rst_b_in(rst_b_in),
		.cmd_in(cmd), .eng_req_out(eng_req), .host_req_out(host_req),
		.wr_hint_out(wr_hint), .rd_hint_out(rd_hint), .busy_out(eng_busy));

	pixel_cache_ctrl #(.FLUSH_CYCLES(4), .RI_CYCLES(4)) dut_u (
		.clk_in(clk_in), .rst_b_in(rst_b_in), .reg_wr_in(reg_wr),
		.reg_rd_in(reg_rd), .reg_addr_in(reg_addr),
		.reg_wdata_in(reg_wdata), .reg_rdata_out(reg_rdata),
		.engine_busy_in(eng_busy), .external_flush_request(ext_flush),
		.external_purge_request(ext_purge),
		.alternate_pixel_format_mode(alt_mode),
		.merge_ways_hint(merge_hint), .engine_req_in(eng_req),
		.host_req_in(host_req), .host_wr_lock_hint_in(wr_hint),
		.host_rd_lock_hint_in(rd_hint), .engine_grant_out(eng_gnt),
		.host_grant_out(host_gnt), .mem_pass_through_out(pass_thru),
		.half_capacity_out(half_cap), .alloc_four_way_out(four_way),
		.flush_active_out(flush_act), .flush_channel_out(flush_chan),
		.invalidate_active_out(inval_act), .purge_busy_out(purge_busy),
		.rise_edge_flush_busy_out(rise_busy),
		.fall_edge_flush_busy_out(fall_busy),
		.engine_busy_out(engine_busy_out), .other_busy_out(other_busy_out));

	// Free-running 125 MHz clock
	initial begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end

	// Cuts a hang short
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			err_count++;
			end_sim;
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge clk_in);
		#1;
	endtask

	task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
		@(posedge clk_in);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk_in);
		reg_wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [15:0] a, output logic [31:0] d);
		@(posedge clk_in);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk_in);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	// Waits for both busy summaries to drop, bounded
	task automatic wait_idle;
		int n;
		n = 0;
		while ((engine_busy_out !== 1'b0 || other_busy_out !== 1'b0)
			&& n < 40) begin
			tick(1);
			n++;
		end
		chk(32'({engine_busy_out, other_busy_out}), 32'h0);
	endtask

	task automatic end_sim;
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		{reg_wr, reg_rd, ext_flush, ext_purge, alt_mode, merge_hint} = '0;
		{reg_addr, reg_wdata, cmd, err_count, check_count, cyc} = '0;
		rst_b_in = 1'b0;
		m = $urandom(81);
		repeat (8) @(posedge clk_in);
		rst_b_in <= 1'b1;
		// Reset values of all registers, unmapped place reads zero
		foreach (addr_tab[i]) begin
			rd_reg(addr_tab[i], rd);
			chk(rd, READ_ZERO);
		end
		// Random static modes; writes only while idle
		for (int i = 0; i < 8; i++) begin
			m = $urandom & 32'h0F8;
			mode_m[i % 2] = m;
			mode_m[1 - i % 2] = 0;
			wr_reg(addr_tab[1 - i % 2], 32'h0);
			wr_reg(addr_tab[i % 2], m | 32'hFFFF_FE00);
			alt_mode   <= 1'($urandom);
			merge_hint <= 1'($urandom);
			tick(3);
			rd_reg(addr_tab[i % 2], rd);
			chk(rd, 32'(mode_m[i % 2]));
			chk(32'(pass_thru), 32'(m[3]));
			chk(32'(half_cap), 32'(m[4] & ~m[3] & ~alt_mode));
			chk(32'(four_way), 32'(merge_hint & ~m[5]));
		end
		wr_reg(OTHER_MODE_OFS, 32'h0);
		wr_reg(ENGINE_MODE_OFS, 32'h0);
		cmd <= 5'h03;
		// Every flush code and invalidate codes 1 and 3, with clients requesting
		foreach (op_tab[i]) begin
			v = op_tab[i];
			wr_reg(CTLSTAT_OFS, v);
			rd_reg(CTLSTAT_OFS, rd);
			chk(rd & 32'hFF, v);
			tick(1);
			chk(32'(engine_busy_out), 32'(|v[3:0]));
			chk(32'(other_busy_out), 32'(|v[7:4]));
			chk(32'(flush_chan), 32'(v[1:0] | v[5:4]));
			chk(32'(flush_act), 32'(|{v[1:0], v[5:4]}));
			chk(32'(inval_act), 32'(|{v[3:2], v[7:6]}));
			chk(32'(eng_gnt), 32'(~|v[3:2]));
			chk(32'(host_gnt), 32'(~|v[7:6]));
			wait_idle;
			rd_reg(CTLSTAT_OFS, rd);
			chk(rd & 32'hFF, 32'h0);
		end
		// A zero write starts nothing
		wr_reg(CTLSTAT_OFS, 32'h0);
		tick(3);
		chk(32'({engine_busy_out, other_busy_out}), 32'h0);
		// Rewriting a running flush restarts its count
		wr_reg(CTLSTAT_OFS, 32'h3);
		tick(1);
		wr_reg(CTLSTAT_OFS, 32'h1);
		tick(4);
		chk(32'(engine_busy_out), 32'h1);
		wait_idle;
		// Engine flush on top of a pending other flush
		wr_reg(CTLSTAT_OFS, 32'h10);
		wr_reg(CTLSTAT_OFS, 32'h01);
		tick(3);
		chk(32'({engine_busy_out, other_busy_out}), 32'h3);
		wait_idle;
		// Host yield to a busy engine
		cmd <= 5'h12;
		tick(4);
		chk(32'(host_gnt), 32'h1);
		wr_reg(ENGINE_MODE_OFS, 32'h1);
		tick(4);
		chk(32'(host_gnt), 32'h0);
		cmd <= 5'h02;
		tick(4);
		chk(32'(host_gnt), 32'h1);
		wr_reg(ENGINE_MODE_OFS, 32'h0);
		// Host lock hints, honoured then ignored
		for (int k = 0; k < 4; k++) begin
			wr_reg(OTHER_MODE_OFS, 32'(k / 2) << (6 + k % 2));
			cmd <= 5'h03 | (5'h04 << (k % 2));
			wr_reg(CTLSTAT_OFS, 32'h40);
			tick(3);
			chk(32'(eng_gnt), 32'(k / 2));
			wait_idle;
		end
		wr_reg(OTHER_MODE_OFS, 32'h0);
		cmd <= 5'h00;
		// Flush and purge edges, enabled, bypassed
		for (int k = 0; k < 4; k++) begin
			wr_reg(ENGINE_MODE_OFS, edge_mode[k]);
			if (k == 3) begin
				ext_purge <= 1'b1;
			end else begin
				ext_flush <= (k != 1);
			end
			tick(5);
			chk(32'({rise_busy, fall_busy, purge_busy}),
				32'(edge_exp[k]));
			tick(14);
			chk(32'({rise_busy, fall_busy, purge_busy}), 32'h0);
		end
		wr_reg(ENGINE_MODE_OFS, 32'h0);
		end_sim;
	end
endmodule // pixel_cache_mode_and_maintenance_test
`default_nettype wire

// ===== verilog/pcache_edge_detect.sv
// Edge detector for one external request level.
// Assumes the input is already synchronous to clk_in.
`timescale 1ns/1ps
`default_nettype none
module pcache_edge_detect (
	input  wire logic clk_in,
	input  wire logic rst_b_in,
	input  wire logic level_in,
	output logic      rise_out,
	output logic      fall_out
);
	logic sampled;
	logic previous;

	// Sample then keep the previous sample for comparison
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sampled  <= 1'b0;
			previous <= 1'b0;
		end else begin
			sampled  <= level_in;
			previous <= sampled;
		end
	end

	// One pulse per edge
	assign rise_out = sampled & ~previous;
	assign fall_out = ~sampled & previous;
endmodule // pcache_edge_detect
`default_nettype wire

// ===== verilog/pcache_op_sequencer.sv
// Counter that walks one maintenance operation over the cache lines.
// Assumes start_in is a one-cycle pulse; a start while running restarts.
`timescale 1ns/1ps
`default_nettype none
module pcache_op_sequencer
	import pcache_pkg::*;
#(
	parameter int LENGTH = DEF_FLUSH_CYCLES
) (
	input  wire logic clk_in,
	input  wire logic rst_b_in,
	input  wire logic start_in,
	output logic      busy_out,
	output logic      done_out
);
	localparam int CW = $clog2(LENGTH + 1);
	localparam logic [CW-1:0] LAST = CW'(LENGTH - 1);

	seq_state_t     state;
	logic [CW-1:0]  count;

	// Restart wins over completion in the same cycle
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state <= SEQ_IDLE;
			count <= '0;
		end else begin
			case (state)
				SEQ_IDLE: begin
					if (start_in) begin
						state <= SEQ_RUN;
						count <= '0;
					end
				end
				SEQ_RUN: begin
					if (start_in) begin
						count <= '0;
					end else if (count == LAST) begin
						state <= SEQ_IDLE;
					end else begin
						count <= count + 1'b1;
					end
				end
				default: state <= SEQ_IDLE;
			endcase
		end
	end

	assign busy_out = (state == SEQ_RUN);
	assign done_out = (state == SEQ_RUN) && (count == LAST) && !start_in;
endmodule // pcache_op_sequencer
`default_nettype wire

// ===== verilog/pixel_cache_ctrl.sv
// Mode and maintenance control for the pixel cache: mode registers,
// flush and read-invalidate control, client admission and busy report.
// Assumes a simple synchronous register port and synchronous inputs.
`timescale 1ns/1ps
`default_nettype none
module pixel_cache_ctrl
	import pcache_pkg::*;
#(
	parameter int FLUSH_CYCLES = DEF_FLUSH_CYCLES,
	parameter int RI_CYCLES    = DEF_RI_CYCLES
) (
	input  wire logic        clk_in,
	input  wire logic        rst_b_in,
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	input  wire logic [15:0] reg_addr_in,
	input  wire logic [31:0] reg_wdata_in,
	output logic      [31:0] reg_rdata_out,
	input  wire logic        engine_busy_in,
	input  wire logic        external_flush_request,
	input  wire logic        external_purge_request,
	input  wire logic        alternate_pixel_format_mode,
	input  wire logic        merge_ways_hint,
	input  wire logic        engine_req_in,
	input  wire logic        host_req_in,
	input  wire logic        host_wr_lock_hint_in,
	input  wire logic        host_rd_lock_hint_in,
	output logic             engine_grant_out,
	output logic             host_grant_out,
	output logic             mem_pass_through_out,
	output logic             half_capacity_out,
	output logic             alloc_four_way_out,
	output logic             flush_active_out,
	output logic       [1:0] flush_channel_out,
	output logic             invalidate_active_out,
	output logic             purge_busy_out,
	output logic             rise_edge_flush_busy_out,
	output logic             fall_edge_flush_busy_out,
	output logic             engine_busy_out,
	output logic             other_busy_out
);
	logic [MODE_WIDTH-1:0] engine_mode_setup;
	logic [MODE_WIDTH-1:0] other_agent_mode_setup;
	logic [MODE_WIDTH-1:0] mode;
	logic [1:0] engine_flush_field;
	logic [1:0] other_flush_field;
	logic [1:0] engine_read_invalidate_field;
	logic [1:0] other_read_invalidate_field;
	logic rise_edge_flush_busy;
	logic fall_edge_flush_busy;
	logic purge_busy;
	logic flush_rise;
	logic flush_fall;
	logic purge_rise;
	logic wr_ctl;
	logic [1:0] wr_eng_flush;
	logic [1:0] wr_oth_flush;
	logic [1:0] wr_eng_ri;
	logic [1:0] wr_oth_ri;
	logic flush_rise_go;
	logic flush_fall_go;
	logic purge_go;
	logic flush_start;
	logic ri_start;
	logic flush_busy;
	logic flush_done;
	logic ri_busy;
	logic ri_done;
	logic engine_block;
	logic host_block;
	logic host_lock;
	logic host_waiting;
	logic edge_flush_status;
	logic engine_busy_status;
	logic other_busy_status;

	// Register select helper for the single-word port
	function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
		hit = (a == o);
	endfunction

	// Effective mode is the union of both setup copies
	assign mode = engine_mode_setup | other_agent_mode_setup;

	pcache_edge_detect u_flush_edge (
		.clk_in   (clk_in),
		.rst_b_in (rst_b_in),
		.level_in (external_flush_request),
		.rise_out (flush_rise),
		.fall_out (flush_fall)
	);

	pcache_edge_detect u_purge_edge (
		.clk_in   (clk_in),
		.rst_b_in (rst_b_in),
		.level_in (external_purge_request),
		.rise_out (purge_rise),
		.fall_out ()
	);

	// Control writes: a zero bit writes nothing
	assign wr_ctl       = reg_wr_in && hit(reg_addr_in, CTLSTAT_OFS);
	assign wr_eng_flush = wr_ctl ? reg_wdata_in[ENG_FLUSH_LSB +: 2] : 2'h0;
	assign wr_oth_flush = wr_ctl ? reg_wdata_in[OTH_FLUSH_LSB +: 2] : 2'h0;
	assign wr_eng_ri    = wr_ctl ? reg_wdata_in[ENG_RI_LSB +: 2] : 2'h0;
	assign wr_oth_ri    = wr_ctl ? reg_wdata_in[OTH_RI_LSB +: 2] : 2'h0;

	// edge flush gated by enable and bypass
	assign flush_rise_go = flush_rise && mode[FLUSH_RISE_EN_BIT]
		&& !mode[BYPASS_BIT];
	assign flush_fall_go = flush_fall && mode[FLUSH_FALL_EN_BIT]
		&& !mode[BYPASS_BIT];
	// purge edge gated by enable and bypass
	assign purge_go = purge_rise && mode[PURGE_RISE_EN_BIT]
		&& !mode[BYPASS_BIT];

	// any new bit restarts the shared flush
	assign flush_start = (|wr_eng_flush) || (|wr_oth_flush)
		|| flush_rise_go || flush_fall_go || purge_go;
	// any new bit restarts the shared invalidate
	assign ri_start = (|wr_eng_ri) || (|wr_oth_ri) || purge_go;

	// One flush walk shared by all requesters
	pcache_op_sequencer #(
		.LENGTH (FLUSH_CYCLES)
	) u_flush_seq (
		.clk_in   (clk_in),
		.rst_b_in (rst_b_in),
		.start_in (flush_start),
		.busy_out (flush_busy),
		.done_out (flush_done)
	);

	// One invalidate walk shared by all requesters
	pcache_op_sequencer #(
		.LENGTH (RI_CYCLES)
	) u_ri_seq (
		.clk_in   (clk_in),
		.rst_b_in (rst_b_in),
		.start_in (ri_start),
		.busy_out (ri_busy),
		.done_out (ri_done)
	);

	// Mode setup registers; written only while idle by agreement
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			engine_mode_setup      <= MODE_RESET;
			other_agent_mode_setup <= MODE_RESET;
		end else if (reg_wr_in) begin
			if (hit(reg_addr_in, ENGINE_MODE_OFS)) begin
				engine_mode_setup <= reg_wdata_in[MODE_WIDTH-1:0];
			end
			if (hit(reg_addr_in, OTHER_MODE_OFS)) begin
				other_agent_mode_setup <= reg_wdata_in[MODE_WIDTH-1:0];
			end
		end
	end

	// flush fields hold until done; a new set wins
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			engine_flush_field <= FIELD_RESET;
			other_flush_field  <= FIELD_RESET;
		end else begin
			engine_flush_field <= (flush_done ? FIELD_RESET
				: engine_flush_field) | wr_eng_flush;
			other_flush_field  <= (flush_done ? FIELD_RESET
				: other_flush_field) | wr_oth_flush;
		end
	end

	// edge status stays until the shared flush completes
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rise_edge_flush_busy <= 1'b0;
			fall_edge_flush_busy <= 1'b0;
		end else begin
			rise_edge_flush_busy <= (rise_edge_flush_busy && !flush_done)
				|| flush_rise_go;
			fall_edge_flush_busy <= (fall_edge_flush_busy && !flush_done)
				|| flush_fall_go;
		end
	end

	// invalidate fields hold until marking completes
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			engine_read_invalidate_field <= FIELD_RESET;
			other_read_invalidate_field  <= FIELD_RESET;
		end else begin
			engine_read_invalidate_field <= (ri_done ? FIELD_RESET
				: engine_read_invalidate_field) | wr_eng_ri;
			other_read_invalidate_field  <= (ri_done ? FIELD_RESET
				: other_read_invalidate_field) | wr_oth_ri;
		end
	end

	// purge holds until both its flush and invalidate walks end
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			purge_busy <= 1'b0;
		end else begin
			purge_busy <= purge_go || (purge_busy
				&& (flush_busy && !flush_done || ri_busy && !ri_done));
		end
	end

	assign engine_block = |engine_read_invalidate_field;
	assign host_block   = |other_read_invalidate_field;
	assign host_waiting = host_req_in && !host_grant_out;
	// host may lock source/Z only where its hint is honoured
	assign host_lock = host_waiting
		&& (host_wr_lock_hint_in && !mode[IGNORE_WR_LOCK_BIT]
		|| host_rd_lock_hint_in && !mode[IGNORE_RD_LOCK_BIT]);

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			engine_grant_out <= 1'b0;
			host_grant_out   <= 1'b0;
		end else begin
			engine_grant_out <= engine_req_in && !engine_block && !host_lock;
			host_grant_out   <= host_req_in && !host_block
				&& !(mode[HOST_YIELD_BIT] && engine_busy_in);
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			mem_pass_through_out <= 1'b0;
			half_capacity_out    <= 1'b0;
			alloc_four_way_out   <= 1'b0;
		end else begin
			mem_pass_through_out <= mode[BYPASS_BIT];
			half_capacity_out    <= mode[HALF_CAP_BIT] && !mode[BYPASS_BIT]
				&& !alternate_pixel_format_mode;
			alloc_four_way_out   <= merge_ways_hint
				&& !mode[IGNORE_MERGE_BIT];
		end
	end

	// Status summaries
	assign edge_flush_status  = rise_edge_flush_busy || fall_edge_flush_busy;
	assign engine_busy_status = (|engine_flush_field)
		|| (|engine_read_invalidate_field);
	assign other_busy_status  = (|other_flush_field)
		|| (|other_read_invalidate_field);

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			flush_active_out         <= 1'b0;
			flush_channel_out        <= FIELD_RESET;
			invalidate_active_out    <= 1'b0;
			purge_busy_out           <= 1'b0;
			rise_edge_flush_busy_out <= 1'b0;
			fall_edge_flush_busy_out <= 1'b0;
			engine_busy_out          <= 1'b0;
			other_busy_out           <= 1'b0;
		end else begin
			flush_active_out         <= flush_busy;
			flush_channel_out        <= (edge_flush_status || purge_busy)
				? FIELD_ALL : (engine_flush_field | other_flush_field);
			invalidate_active_out    <= ri_busy;
			purge_busy_out           <= purge_busy;
			rise_edge_flush_busy_out <= rise_edge_flush_busy;
			fall_edge_flush_busy_out <= fall_edge_flush_busy;
			engine_busy_out          <= engine_busy_status;
			other_busy_out           <= other_busy_status;
		end
	end

	// Read data; reads have no side effects, unmapped reads give zero
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			reg_rdata_out <= READ_ZERO;
		end else if (reg_rd_in) begin
			reg_rdata_out <= READ_ZERO;
			if (hit(reg_addr_in, ENGINE_MODE_OFS)) begin
				reg_rdata_out[MODE_WIDTH-1:0] <= engine_mode_setup;
			end else if (hit(reg_addr_in, OTHER_MODE_OFS)) begin
				reg_rdata_out[MODE_WIDTH-1:0] <= other_agent_mode_setup;
			end else if (hit(reg_addr_in, CTLSTAT_OFS)) begin
				reg_rdata_out[ENG_FLUSH_LSB +: 2] <= engine_flush_field;
				reg_rdata_out[ENG_RI_LSB +: 2] <= engine_read_invalidate_field;
				reg_rdata_out[OTH_FLUSH_LSB +: 2] <= other_flush_field;
				reg_rdata_out[OTH_RI_LSB +: 2] <= other_read_invalidate_field;
				reg_rdata_out[PURGE_STATUS_BIT]    <= purge_busy;
				reg_rdata_out[EDGE_FLUSH_STAT_BIT] <= edge_flush_status;
				reg_rdata_out[ENG_BUSY_STAT_BIT]   <= engine_busy_status;
				reg_rdata_out[OTH_BUSY_STAT_BIT]   <= other_busy_status;
			end
		end
	end

	// Checks on the block's own behaviour
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);

	sequence s_full_flush_write;
		wr_ctl && reg_wdata_in[ENG_FLUSH_LSB +: 2] == FIELD_ALL;
	endsequence

	sequence s_flush_held;
		engine_flush_field == FIELD_ALL && flush_busy;
	endsequence

	property p_host_yield;
		mode[HOST_YIELD_BIT] && engine_busy_in |=> !host_grant_out;
	endproperty
	a_host_yield: assert property (p_host_yield)
		else $error("host granted while engine busy and yield set");

	property p_rise_flush;
		flush_rise_go |=> rise_edge_flush_busy && flush_busy
			##1 rise_edge_flush_busy_out;
	endproperty
	a_rise_flush: assert property (p_rise_flush)
		else $error("rising edge did not start a reported flush");

	property p_fall_flush;
		flush_fall_go |=> fall_edge_flush_busy && flush_busy;
	endproperty
	a_fall_flush: assert property (p_fall_flush)
		else $error("falling edge did not start a reported flush");

	property p_bypass;
		mode[BYPASS_BIT] |=> mem_pass_through_out && !half_capacity_out;
	endproperty
	a_bypass: assert property (p_bypass)
		else $error("bypass not passed to memory ports");

	property p_half_inhibit;
		alternate_pixel_format_mode |=> !half_capacity_out;
	endproperty
	a_half_inhibit: assert property (p_half_inhibit)
		else $error("half capacity used in alternate format");

	property p_merge;
		merge_ways_hint |=> alloc_four_way_out == $past(!mode[IGNORE_MERGE_BIT]);
	endproperty
	a_merge: assert property (p_merge)
		else $error("merge hint handling wrong");

	property p_purge;
		purge_go |=> purge_busy && flush_busy && ri_busy;
	endproperty
	a_purge: assert property (p_purge)
		else $error("purge edge did not start purge");

	property p_full_flush;
		s_full_flush_write |=> s_flush_held;
	endproperty
	a_full_flush: assert property (p_full_flush)
		else $error("full flush write not taken");

	property p_flush_clear;
		flush_done && !flush_start |=> engine_flush_field == FIELD_RESET
			&& !flush_busy ##1 !engine_busy_out || engine_busy_status;
	endproperty
	a_flush_clear: assert property (p_flush_clear)
		else $error("flush field not cleared at completion");

	property p_ri_block;
		engine_read_invalidate_field != FIELD_RESET |=> !engine_grant_out;
	endproperty
	a_ri_block: assert property (p_ri_block)
		else $error("engine granted during read invalidate");

	property p_shared_flush;
		(|wr_eng_flush) && (|wr_oth_flush) |=> engine_busy_status
			&& other_busy_status ##1 engine_busy_out && other_busy_out;
	endproperty
	a_shared_flush: assert property (p_shared_flush)
		else $error("shared flush not shown in both fields");

endmodule // pixel_cache_ctrl
`default_nettype wire
